//--- core/pwm_core.sv
// Purpose: Pulse-width modulator with APB registers
// Assumes: Single clock, APB slave with zero wait states
// Notes:   Flag sets win over the read-clear
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module pwm_core #(
    parameter int W = 16
) (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic        ce_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic             pwm_o,
    output logic             irq_o
);
    typedef struct packed {
        logic         irq;
        logic         ien;
        logic         load;
        logic         output_invert;
        logic         en;
        logic [2:0]   sel;
        logic [W-1:0] per_buf;
        logic [W-1:0] wid_buf;
        logic [W-1:0] per_cmp;
        logic [W-1:0] wid_cmp;
        logic [W-1:0] cnt;
        logic         act;
        logic [31:0]  rdata;
    } pwm_state_t;

    pwm_state_t st_r;
    pwm_state_t st_nxt;
    pwm_tick_if tk ();

    logic acc;
    logic wr;
    logic rd;
    logic setup_rd;
    logic hit;
    logic [15:0] ctrl_view;
    logic        per_hit;
    logic        wid_hit;
    logic        restart;
    logic        en_rise;
    logic        lvl;

    assign acc = psel_i && penable_i;
    assign wr  = acc && pwrite_i;
    assign rd  = acc && !pwrite_i;
    // Read data registered in setup so it stands through the access phase
    assign setup_rd = psel_i && !penable_i && !pwrite_i;
    assign hit = (paddr_i == pwm_pkg::PWM_OFF_CTRL) || (paddr_i == pwm_pkg::PWM_OFF_PERIOD)
              || (paddr_i == pwm_pkg::PWM_OFF_WIDTH) || (paddr_i == pwm_pkg::PWM_OFF_COUNT);
    assign pready_o  = 1'b1;
    assign pslverr_o = acc && !hit;

    // Output level is the internal active state, flipped by polarity
    assign lvl   = st_r.act ^ st_r.output_invert;
    assign pwm_o = lvl;
    assign irq_o = st_r.irq && st_r.ien;
    assign prdata_o = st_r.rdata;

    always_comb begin
        ctrl_view = 16'h0000;
        ctrl_view[pwm_pkg::PWM_BIT_IRQ]  = st_r.irq;
        ctrl_view[pwm_pkg::PWM_BIT_IEN]  = st_r.ien;
        ctrl_view[pwm_pkg::PWM_BIT_LOAD] = st_r.load;
        ctrl_view[pwm_pkg::PWM_BIT_PIN]  = lvl;
        ctrl_view[pwm_pkg::PWM_BIT_POL]  = st_r.output_invert;
        ctrl_view[pwm_pkg::PWM_BIT_EN]   = st_r.en;
        ctrl_view[2:0] = st_r.sel;
    end

    assign tk.run = st_r.en;
    assign tk.sel = st_r.sel;

    pwm_prescaler u_div (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .ce_i   (ce_i),
        .tk     (tk)
    );

    // Comparators only look once the counter ticks
    assign per_hit = st_r.en && tk.tick && (st_r.cnt == st_r.per_cmp);
    assign wid_hit = st_r.en && tk.tick && (st_r.cnt == st_r.wid_cmp);
    assign restart = per_hit || (st_r.en && tk.tick && st_r.load);
    assign en_rise = wr && (paddr_i == pwm_pkg::PWM_OFF_CTRL) && pstrb_i[0]
                   && pwdata_i[pwm_pkg::PWM_BIT_EN] && !st_r.en;

    always_comb begin
        st_nxt = st_r;
        // Read-clear first so a same-cycle set wins
        // Clear only a flag the reader has actually seen
        if (rd && paddr_i == pwm_pkg::PWM_OFF_CTRL && st_r.rdata[pwm_pkg::PWM_BIT_IRQ]) begin
            st_nxt.irq = 1'b0;
        end
        if (setup_rd) begin
            unique case (paddr_i)
                pwm_pkg::PWM_OFF_CTRL:   st_nxt.rdata = {16'h0000, ctrl_view};
                pwm_pkg::PWM_OFF_PERIOD: st_nxt.rdata = 32'(st_r.per_buf);
                pwm_pkg::PWM_OFF_WIDTH:  st_nxt.rdata = 32'(st_r.wid_buf);
                pwm_pkg::PWM_OFF_COUNT:  st_nxt.rdata = 32'(st_r.cnt);
                default:                 st_nxt.rdata = 32'h0000_0000;
            endcase
        end
        if (wr) begin
            unique case (paddr_i)
                pwm_pkg::PWM_OFF_CTRL: begin
                    if (pstrb_i[1]) begin
                        st_nxt.ien = pwdata_i[pwm_pkg::PWM_BIT_IEN];
                        if (pwdata_i[pwm_pkg::PWM_BIT_IRQ]) begin
                            st_nxt.irq = 1'b1;
                        end
                        if (pwdata_i[pwm_pkg::PWM_BIT_LOAD]) begin
                            st_nxt.load = 1'b1;
                        end
                    end
                    if (pstrb_i[0]) begin
                        st_nxt.output_invert = pwdata_i[pwm_pkg::PWM_BIT_POL];
                        st_nxt.en  = pwdata_i[pwm_pkg::PWM_BIT_EN];
                        st_nxt.sel = pwdata_i[2:0];
                    end
                end
                pwm_pkg::PWM_OFF_PERIOD: begin
                    if (pstrb_i[0]) st_nxt.per_buf[7:0] = pwdata_i[7:0];
                    if (pstrb_i[1]) st_nxt.per_buf[W-1:8] = pwdata_i[W-1:8];
                end
                pwm_pkg::PWM_OFF_WIDTH: begin
                    if (pstrb_i[0]) st_nxt.wid_buf[7:0] = pwdata_i[7:0];
                    if (pstrb_i[1]) st_nxt.wid_buf[W-1:8] = pwdata_i[W-1:8];
                end
                default: begin
                end
            endcase
        end
        if (!st_r.en) begin
            st_nxt.cnt     = W'(pwm_pkg::PWM_CNT_IDLE);
            st_nxt.per_cmp = st_r.per_buf;
            st_nxt.wid_cmp = st_r.wid_buf;
            st_nxt.act     = 1'b0;
            st_nxt.load    = 1'b0;
            if (en_rise) begin
                // Enable starts a period with output active unless the buffered period is zero
                st_nxt.act = (st_r.per_buf != '0);
                if (st_nxt.ien) begin
                    st_nxt.irq = 1'b1;
                end
            end
        end else if (restart) begin
            st_nxt.cnt     = W'(pwm_pkg::PWM_CNT_IDLE);
            st_nxt.per_cmp = st_r.per_buf;
            st_nxt.wid_cmp = st_r.wid_buf;
            st_nxt.act     = (st_r.per_buf != '0);
            st_nxt.load    = 1'b0;
            if (per_hit) begin
                st_nxt.irq = 1'b1;
            end
        end else if (tk.tick) begin
            st_nxt.cnt = st_r.cnt + W'(1);
            if (wid_hit) begin
                st_nxt.act = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r     <= '0;
            st_r.cnt <= W'(pwm_pkg::PWM_CNT_IDLE);
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    sequence s_per_match;
        st_r.en && tk.tick && st_r.cnt == st_r.per_cmp;
    endsequence

    a_period_restart: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (ce_i and s_per_match) |=> st_r.cnt == W'(pwm_pkg::PWM_CNT_IDLE))
        else $error("counter not restarted at period match");
    a_period_flag: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (ce_i and s_per_match) |=> st_r.irq)
        else $error("period flag not set");
    a_width_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i && wid_hit && !restart |=> !st_r.act)
        else $error("output not cleared at width match");
    a_irq_gate: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !st_r.ien |-> !irq_o)
        else $error("interrupt while disabled");
    a_read_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i && rd && paddr_i == pwm_pkg::PWM_OFF_CTRL && st_r.rdata[pwm_pkg::PWM_BIT_IRQ]
        && !per_hit && !wr
        |=> !st_r.irq)
        else $error("flag not cleared by read");
    a_idle_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !st_r.en && !en_rise ##1 !st_r.en |-> st_r.cnt == W'(pwm_pkg::PWM_CNT_IDLE)
        && pwm_o == st_r.output_invert)
        else $error("idle state wrong");
    a_zero_period: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i && restart && st_r.per_buf == '0 |=> !st_r.act)
        else $error("zero period drove output active");
    a_count_step: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i && st_r.en && tk.tick && !restart |=> st_r.cnt == $past(st_r.cnt) + W'(1))
        else $error("counter did not step");
    a_load_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i && st_r.en && tk.tick && st_r.load |=> !st_r.load && st_r.cnt == W'(1))
        else $error("load not performed");
    a_pin_view: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ctrl_view[pwm_pkg::PWM_BIT_PIN] == pwm_o)
        else $error("pin bit mismatch");
endmodule
`default_nettype wire

//--- core/pwm_prescaler.sv
// Purpose: Divides the clock by 4 to 512 into a tick pulse
// Assumes: Run low clears the divider
// Notes:   Tick lands on the last cycle of each divided period
`timescale 1ns/1ps
`default_nettype none
module pwm_prescaler (
    input  wire logic  clk_i,
    input  wire logic  rstn_i,
    input  wire logic  ce_i,
    pwm_tick_if.div    tk
);
    typedef struct packed {
        logic [8:0] cnt;
    } pwm_div_t;
    pwm_div_t st_r;
    pwm_div_t st_nxt;
    logic [8:0] limit;

    // Widened so that divide by 512 does not wrap before the subtraction
    assign limit = 9'((10'(pwm_pkg::PWM_DIV_BASE) << tk.sel) - 10'h001);
    assign tk.tick = ce_i && tk.run && (st_r.cnt == limit);

    always_comb begin
        st_nxt = st_r;
        if (!tk.run) begin
            st_nxt.cnt = '0;
        end else if (tk.tick) begin
            st_nxt.cnt = '0;
        end else begin
            st_nxt.cnt = st_r.cnt + 9'h001;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r <= '0;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    a_tick_spacing: assert property (@(posedge clk_i) disable iff (!rstn_i)
        tk.tick && tk.sel == 3'h0 && $stable(tk.sel) |=> !tk.tick [*3])
        else $error("prescaler tick too soon");
endmodule
`default_nettype wire

//--- shared/pwm_pkg.sv
// What this block does
// - When the counter equals the latched period the output goes active and the counter restarts.
// - When the counter equals the latched width the output goes inactive for the rest of the period.
// - Period and width are buffered and copied to the comparators only at each period start and on every cycle while disabled.
// - Prescale select codes 0 to 7 divide the clock by 4, 8, 16, 32, 64, 128, 256 and 512.
// - Each period match sets the period flag and, with interrupts enabled, raises the request.
// - Software writing one to the period flag sets it at once and, with interrupts enabled, posts an interrupt.
// - Reading the control register while the period flag is one clears the flag.
// - With interrupts disabled no request is raised but the flag still updates for polling.
// - Writing one to the load bit restarts the period and reloads the comparators on the next tick, then the bit clears.
// - The read-only pin bit shows the present output level.
// - Polarity zero gives high at period start and low at width match; polarity one inverts both.
// - While disabled the prescaler is reset, the counter held at 0001, comparators loaded and idle, output at polarity level.
// - On enable a new period starts, the output goes active unless the period is zero, counting resumes and the flag is set if interrupts are enabled.
// - A period of zero never sets the output active.
// - A width above the period never returns the output inactive.
// - The counter can be read at any time without disturbing it.
// Purpose: Constants for the pulse-width modulator
// Assumes: APB, 32-bit data, word-aligned registers
// Notes:   Offsets are byte addresses
package pwm_pkg;
    localparam logic [11:0] PWM_OFF_CTRL   = 12'h000;
    localparam logic [11:0] PWM_OFF_PERIOD = 12'h004;
    localparam logic [11:0] PWM_OFF_WIDTH  = 12'h008;
    localparam logic [11:0] PWM_OFF_COUNT  = 12'h00c;
    localparam int PWM_BIT_IRQ  = 15;
    localparam int PWM_BIT_IEN  = 14;
    localparam int PWM_BIT_LOAD = 8;
    localparam int PWM_BIT_PIN  = 7;
    localparam int PWM_BIT_POL  = 5;
    localparam int PWM_BIT_EN   = 4;
    localparam logic [15:0] PWM_RST_REG   = 16'h0000;
    localparam logic [15:0] PWM_CNT_IDLE  = 16'h0001;
    localparam logic [8:0]  PWM_DIV_BASE  = 9'h004;
endpackage

//--- shared/pwm_tick_if.sv
// Purpose: Prescaler control and tick between modulator and divider
// Assumes: Single clock domain
// Notes:   Tick is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface pwm_tick_if;
    logic       run;
    logic [2:0] sel;
    logic       tick;
    modport ctl (output run, output sel, input tick);
    modport div (input run, input sel, output tick);
endinterface
`default_nettype wire

//--- test/pwm_load_model.sv
// Purpose: Load on the modulator pin, measures period and high time
// Assumes: One clock domain, pin sampled each rising edge
// Notes:   Results latch at each rising pin edge
`timescale 1ns/1ps
`default_nettype none
module pwm_load_model (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic        pwm_i,
    output logic      [15:0] per_o,
    output logic      [15:0] hi_o
);
    logic        prev_r;
    logic [15:0] run_r;
    logic [15:0] hrun_r;
    // Filter sees only edges, so a steady pin leaves the last figures
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prev_r <= 1'b0;
            run_r  <= 16'h0000;
            hrun_r <= 16'h0000;
            per_o  <= 16'h0000;
            hi_o   <= 16'h0000;
        end else begin
            prev_r <= pwm_i;
            if (pwm_i && !prev_r) begin
                per_o  <= run_r;
                hi_o   <= hrun_r;
                run_r  <= 16'h0001;
                hrun_r <= 16'h0001;
            end else begin
                run_r  <= run_r + 16'h0001;
                hrun_r <= hrun_r + {15'h0000, pwm_i};
            end
        end
    end
endmodule
`default_nettype wire

//--- test/testbench.sv
// Purpose: Register-level tests of the pulse-width modulator
// Assumes: APB, read data taken at the edge that sees pready high
// Notes:   Clock enable and strobes held on
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk_i = 0, rstn_i = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic        pready, pslverr, pwm, irq, err;
    logic [15:0] per, hi;
    int          n_fail = 0, num_checks = 0, nh;
    pwm_core i_pwm_core (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .pstrb_i(4'hf), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .pwm_o(pwm), .irq_o(irq));
    pwm_load_model i_pwm_load_model (.clk_i(clk_i), .rstn_i(rstn_i), .pwm_i(pwm),
        .per_o(per), .hi_o(hi));
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do @(posedge clk_i); while (pready !== 1'b1);
        err = pslverr;
        rd  = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        // One idle edge so outputs after a write are settled when looked at
        @(posedge clk_i);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic cfg(input logic [15:0] p, input logic [15:0] w, input logic [15:0] c);
        apb(1'b1, pwm_pkg::PWM_OFF_CTRL, 32'h0);
        apb(1'b1, pwm_pkg::PWM_OFF_PERIOD, {16'h0, p});
        apb(1'b1, pwm_pkg::PWM_OFF_WIDTH, {16'h0, w});
        apb(1'b1, pwm_pkg::PWM_OFF_CTRL, {16'h0, c});
    endtask
    task automatic count_high(input int n);
        nh = 0;
        repeat (n) begin
            @(posedge clk_i);
            nh += (pwm === 1'b1) ? 1 : 0;
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        print_verdict();
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rstn_i <= 1'b1;
        rdchk(pwm_pkg::PWM_OFF_CTRL, 32'h0);
        rdchk(pwm_pkg::PWM_OFF_PERIOD, 32'h0);
        rdchk(pwm_pkg::PWM_OFF_WIDTH, 32'h0);
        rdchk(pwm_pkg::PWM_OFF_COUNT, 32'h1);
        rdchk(12'h010, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test reset done");
        apb(1'b1, pwm_pkg::PWM_OFF_CTRL, 32'h20);
        chk({31'h0, pwm}, 32'h1);
        rdchk(pwm_pkg::PWM_OFF_CTRL, 32'ha0);
        apb(1'b1, pwm_pkg::PWM_OFF_CTRL, 32'hc000);
        chk({31'h0, irq}, 32'h1);
        rdchk(pwm_pkg::PWM_OFF_CTRL, 32'hc000);
        rdchk(pwm_pkg::PWM_OFF_CTRL, 32'h4000);
        chk({31'h0, irq}, 32'h0);
        $display("test flag done");
        // Width two of period four: two ticks high, two low, tick of four clocks
        cfg(16'h4, 16'h2, 16'h4010);
        repeat (48) @(posedge clk_i);
        chk({16'h0, per}, 32'd16);
        chk({16'h0, hi}, 32'd8);
        chk({31'h0, irq}, 32'h1);
        // Width three inverted: active three ticks, so pin high one tick
        cfg(16'h4, 16'h3, 16'h0030);
        repeat (48) @(posedge clk_i);
        chk({16'h0, hi}, 32'd4);
        $display("test wave done");
        for (int s = 0; s < 8; s++) begin
            cfg(16'h2, 16'h1, 16'h0010 | 16'(s));
            repeat (3 * (8 << s)) @(posedge clk_i);
            chk({16'h0, per}, 32'(8 << s));
            chk({16'h0, hi}, 32'(4 << s));
            chk({31'h0, irq}, 32'h0);
            apb(1'b0, pwm_pkg::PWM_OFF_CTRL, 32'h0);
            chk({31'h0, rd[15]}, 32'h1);
        end
        $display("test prescale done");
        cfg(16'h0, 16'h2, 16'h0010);
        count_high(64);
        chk(32'(nh), 32'd0);
        cfg(16'h4, 16'h5, 16'h0010);
        count_high(64);
        chk(32'(nh), 32'd64);
        $display("test duty limits done");
        print_verdict();
    end
endmodule
`default_nettype wire
